// ---- logic/sas_pkg.sv ----
package sas_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int REG_W = 8;
  localparam logic [APB_AW-1:0] ADDR_CONTROL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_CONFIG = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_RESULT_HIGH = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_RESULT_LOW = 8'h0c;
  localparam logic [APB_AW-1:0] ADDR_DONE_FLAG = 8'h10;
  localparam logic [APB_AW-1:0] ADDR_IRQ_ENABLE = 8'h14;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int CTRL_CHS_LSB = 2;
  localparam int CHS_W = 5;
  localparam int CFG_PREF_LSB = 0;
  localparam int PREF_W = 2;
  localparam int CFG_NREF_BIT = 2;
  localparam int CFG_CS_LSB = 4;
  localparam int CS_W = 3;
  localparam int CFG_FMT_BIT = 7;
  localparam int FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 0;
  localparam logic [REG_W-1:0] CONFIG_WMASK = 8'hf7;
  localparam logic [CHS_W-1:0] CHS_RESET = 5'h00;
  localparam logic [REG_W-1:0] CONFIG_RESET = 8'h00;
  localparam logic [REG_W-1:0] RESULT_RESET = 8'h00;

  // ****************************************
  // Codes
  // ****************************************
  localparam int RES_W = 10;
  localparam int IDX_W = 4;
  localparam logic [CHS_W-1:0] CHS_LAST_ANALOG = 5'h0d;
  localparam logic [CHS_W-1:0] CHS_TEMP_REF = 5'h1d;
  localparam logic [CHS_W-1:0] CHS_DAC_OUT = 5'h1e;
  localparam logic [CHS_W-1:0] CHS_FIXED_REF = 5'h1f;
  localparam logic [PREF_W-1:0] PREF_SUPPLY = 2'h0;
  localparam logic [PREF_W-1:0] PREF_EXTERNAL = 2'h2;
  localparam logic [PREF_W-1:0] PREF_FIXED = 2'h3;
  localparam logic [CS_W-1:0] CS_DIV2 = 3'h0;
  localparam logic [CS_W-1:0] CS_DIV4 = 3'h4;
  localparam logic [CS_W-1:0] CS_DIV8 = 3'h1;
  localparam logic [CS_W-1:0] CS_DIV16 = 3'h5;
  localparam logic [CS_W-1:0] CS_DIV32 = 3'h2;
  localparam logic [CS_W-1:0] CS_DIV64 = 3'h6;
  localparam logic [1:0] CS_RC_LOW = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int HALF_W = 5;
  localparam logic [HALF_W-1:0] HALF_DIV2 = 5'd1;
  localparam logic [HALF_W-1:0] HALF_DIV4 = 5'd2;
  localparam logic [HALF_W-1:0] HALF_DIV8 = 5'd4;
  localparam logic [HALF_W-1:0] HALF_DIV16 = 5'd8;
  localparam logic [HALF_W-1:0] HALF_DIV32 = 5'd16;
  localparam logic [HALF_W-1:0] HALF_DIV64 = 5'd31;
  localparam logic [HALF_W-1:0] HALF_DIV64_FIX = 5'd1;
  localparam logic [1:0] HOLD_HALF_TICKS = 2'd3;
  localparam int CLK_PERIOD_NS = 100;
  localparam int INSTR_CYCLE_NS = 400;
  localparam int START_DELAY_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] START_DELAY_LAST = 3'(START_DELAY_CLKS - 1);

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_DELAY,
    SEQ_HOLD,
    SEQ_BITS
  } sas_state_t;

endpackage

// ---- logic/sas_tick_if.sv ----
`timescale 1ns/1ps
interface sas_tick_if;
  logic [2:0] clk_sel;
  logic run;
  logic rc_tick;
  logic half_tick;
  modport gen (input clk_sel, input run, input rc_tick, output half_tick);
  modport seq (output clk_sel, output run, output rc_tick, input half_tick);
endinterface

// ---- logic/sas_tick_gen.sv ----
`timescale 1ns/1ps
module sas_tick_gen (
  input wire logic pclk,
  input wire logic presetn,
  sas_tick_if.gen tk
);
  import sas_pkg::*;

  // ****************************************
  // Half bit-period divider
  // ****************************************
  logic [HALF_W-1:0] cnt;
  logic [HALF_W-1:0] limit;
  logic [HALF_W-1:0] last;

  always_comb begin
    case (tk.clk_sel)
      CS_DIV2: limit = HALF_DIV2;
      CS_DIV4: limit = HALF_DIV4;
      CS_DIV8: limit = HALF_DIV8;
      CS_DIV16: limit = HALF_DIV16;
      CS_DIV32: limit = HALF_DIV32;
      default: limit = HALF_DIV32;
    endcase
  end

  // Divide by 64 needs 32 clocks per half period, one past the counter range
  assign last = (tk.clk_sel == CS_DIV64) ? HALF_DIV64 : limit - HALF_DIV64_FIX;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      tk.half_tick <= 1'b0;
    end else if (!tk.run) begin
      cnt <= '0;
      tk.half_tick <= 1'b0;
    end else if (tk.clk_sel[1:0] == CS_RC_LOW) begin
      cnt <= '0;
      tk.half_tick <= tk.rc_tick;
    end else if (cnt == last) begin
      cnt <= '0;
      tk.half_tick <= 1'b1;
    end else begin
      cnt <= cnt + HALF_DIV64_FIX;
      tk.half_tick <= 1'b0;
    end
  end

endmodule

// ---- logic/sas_adc_seq.sv ----
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module sas_adc_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sas_pkg::APB_AW-1:0] paddr,
  input wire logic [sas_pkg::APB_DW-1:0] pwdata,
  output logic [sas_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_active,
  input wire logic rc_tick,
  input wire logic compare_trigger,
  input wire logic cmp_high,
  output logic converter_powered,
  output logic sample_hold,
  output logic [sas_pkg::RES_W-1:0] sar_code,
  output logic [3:0] ain_index,
  output logic ain_connect,
  output logic temp_ref_connect,
  output logic dac_connect,
  output logic fixed_ref_connect,
  output logic nref_external,
  output logic pref_supply,
  output logic pref_external,
  output logic pref_fixed,
  output logic trigger_timer_reset,
  output logic conversion_irq,
  output logic wake_request
);
  import sas_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic converter_on;
  logic go_busy;
  logic [CHS_W-1:0] channel_select;
  logic [REG_W-1:0] conversion_config;
  logic [REG_W-1:0] result_high;
  logic [REG_W-1:0] result_low;
  logic conversion_done_flag;
  logic conversion_irq_enable;
  logic sleep_off_latch;
  sas_state_t state;
  logic [1:0] hold_cnt;
  logic [2:0] delay_cnt;
  logic [IDX_W-1:0] bit_idx;
  logic bit_phase;
  logic [RES_W-1:0] sar;

  logic addr_hit;
  logic [REG_W-1:0] rd_byte;
  logic access;
  logic wr_control;
  logic wr_config;
  logic wr_flag;
  logic wr_irq_en;
  logic rc_selected;
  logic sleep_abort;
  logic can_start;
  logic start_req;
  logic sw_abort;
  logic off_abort;
  logic complete;
  logic load_result;
  logic [RES_W-1:0] next_result;
  logic [RES_W-1:0] partial;
  logic gated_on;

  sas_tick_if tick ();

  sas_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tick)
  );

  // ****************************************
  // APB decode and read path
  // ****************************************
  always_comb begin
    addr_hit = 1'b1;
    rd_byte = '0;
    case (paddr)
      ADDR_CONTROL: rd_byte = {1'b0, channel_select, go_busy, converter_on};
      ADDR_CONFIG: rd_byte = conversion_config & CONFIG_WMASK;
      ADDR_RESULT_HIGH: rd_byte = result_high;
      ADDR_RESULT_LOW: rd_byte = result_low;
      ADDR_DONE_FLAG: rd_byte = {7'h00, conversion_done_flag};
      ADDR_IRQ_ENABLE: rd_byte = {7'h00, conversion_irq_enable};
      default: addr_hit = 1'b0;
    endcase
  end

  // One wait state so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata <= {24'h000000, rd_byte};
      pslverr <= ~addr_hit;
    end else begin
      pslverr <= 1'b0;
    end
  end

  assign access = psel & penable & pready & addr_hit & pwrite;
  assign wr_control = access & (paddr == ADDR_CONTROL);
  assign wr_config = access & (paddr == ADDR_CONFIG);
  assign wr_flag = access & (paddr == ADDR_DONE_FLAG);
  assign wr_irq_en = access & (paddr == ADDR_IRQ_ENABLE);

  // ****************************************
  // Start, abort and completion conditions
  // ****************************************
  assign rc_selected = conversion_config[CFG_CS_LSB +: 2] == CS_RC_LOW;
  assign sleep_abort = sleep_active & ~rc_selected;
  assign gated_on = converter_on & ~sleep_off_latch & ~sleep_abort;
  assign can_start = gated_on & (state == SEQ_IDLE);
  assign start_req = can_start & ((wr_control & pwdata[CTRL_GO_BIT] & pwdata[CTRL_ON_BIT]) | compare_trigger);
  assign sw_abort = wr_control & go_busy & ~pwdata[CTRL_GO_BIT] & pwdata[CTRL_ON_BIT];
  // Turning off, or sleeping without the RC clock selected, drops the conversion with no result
  assign off_abort = go_busy & ((wr_control & ~pwdata[CTRL_ON_BIT]) | ~gated_on);
  assign complete = (state == SEQ_BITS) & tick.half_tick & bit_phase & (bit_idx == '0) & ~off_abort & ~sw_abort;
  assign load_result = complete | (sw_abort & ~off_abort);

  // unconverted bits copy the last one decided
  always_comb begin
    partial = sar;
    for (int i = 0; i < RES_W; i++) begin
      if ((state != SEQ_BITS) || (i[IDX_W-1:0] <= bit_idx)) begin
        partial[i] = (state == SEQ_BITS) && (bit_idx != IDX_W'(RES_W - 1)) ? sar[bit_idx + 1'b1] : 1'b0;
      end
    end
  end

  always_comb begin
    next_result = partial;
    if (complete) begin
      next_result = {sar[RES_W-1:1], cmp_high};
    end
  end

  // ****************************************
  // Tick generator hookup
  // ****************************************
  assign tick.clk_sel = conversion_config[CFG_CS_LSB +: CS_W];
  assign tick.run = (state == SEQ_HOLD) | (state == SEQ_BITS);
  assign tick.rc_tick = rc_tick;

  // ****************************************
  // Control, config and IRQ enable registers
  // ****************************************
  // reset clears all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_on <= 1'b0;
      channel_select <= CHS_RESET;
    end else if (wr_control) begin
      converter_on <= pwdata[CTRL_ON_BIT];
      channel_select <= pwdata[CTRL_CHS_LSB +: CHS_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_config <= CONFIG_RESET;
    end else if (wr_config) begin
      conversion_config <= pwdata[REG_W-1:0] & CONFIG_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_irq_enable <= 1'b0;
    end else if (wr_irq_en) begin
      conversion_irq_enable <= pwdata[IRQ_EN_BIT];
    end
  end

  // ****************************************
  // Done flag, set wins over clear
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_flag <= 1'b0;
    end else if (complete) begin
      conversion_done_flag <= 1'b1;
    end else if (wr_flag & pwdata[FLAG_BIT]) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // ****************************************
  // Sleep power-down latch
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_off_latch <= 1'b0;
    end else if (!sleep_active) begin
      sleep_off_latch <= 1'b0;
    end else if (complete & rc_selected & ~conversion_irq_enable) begin
      sleep_off_latch <= 1'b1;
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SEQ_IDLE;
      go_busy <= 1'b0;
      hold_cnt <= '0;
      delay_cnt <= '0;
      bit_idx <= '0;
      bit_phase <= 1'b0;
      sar <= '0;
    end else if (sw_abort | off_abort | complete) begin
      state <= SEQ_IDLE;
      go_busy <= 1'b0;
      bit_phase <= 1'b0;
    end else begin
      case (state)
        SEQ_IDLE: begin
          if (start_req) begin
            go_busy <= 1'b1;
            hold_cnt <= '0;
            delay_cnt <= '0;
            sar <= '0;
            state <= rc_selected ? SEQ_DELAY : SEQ_HOLD;
          end
        end
        SEQ_DELAY: begin
          if (delay_cnt == START_DELAY_LAST) begin
            state <= SEQ_HOLD;
          end else begin
            delay_cnt <= delay_cnt + 3'd1;
          end
        end
        SEQ_HOLD: begin
          if (tick.half_tick) begin
            if (hold_cnt == HOLD_HALF_TICKS - 2'd1) begin
              state <= SEQ_BITS;
              bit_idx <= IDX_W'(RES_W - 1);
              bit_phase <= 1'b0;
              sar <= {1'b1, {(RES_W-1){1'b0}}};
            end else begin
              hold_cnt <= hold_cnt + 2'd1;
            end
          end
        end
        SEQ_BITS: begin
          if (tick.half_tick) begin
            bit_phase <= ~bit_phase;
            if (bit_phase) begin
              sar[bit_idx] <= cmp_high;
              sar[bit_idx - 1'b1] <= 1'b1;
              bit_idx <= bit_idx - 1'b1;
            end
          end
        end
        default: begin
          state <= SEQ_IDLE;
          go_busy <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Result registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_high <= RESULT_RESET;
      result_low <= RESULT_RESET;
    end else if (load_result) begin
      if (conversion_config[CFG_FMT_BIT]) begin
        result_high <= {6'h00, next_result[RES_W-1 -: 2]};
        result_low <= next_result[REG_W-1:0];
      end else begin
        result_high <= next_result[RES_W-1 -: REG_W];
        result_low <= {next_result[1:0], 6'h00};
      end
    end
  end

  // ****************************************
  // Analog side drive
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_powered <= 1'b0;
      sample_hold <= 1'b0;
      sar_code <= '0;
    end else begin
      converter_powered <= gated_on;
      // Falls with power on abort, never outlives the supply
      sample_hold <= go_busy & ~off_abort & (state != SEQ_DELAY);
      sar_code <= sar;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ain_index <= '0;
      ain_connect <= 1'b0;
      temp_ref_connect <= 1'b0;
      dac_connect <= 1'b0;
      fixed_ref_connect <= 1'b0;
    end else begin
      ain_index <= channel_select[3:0];
      ain_connect <= channel_select <= CHS_LAST_ANALOG;
      temp_ref_connect <= channel_select == CHS_TEMP_REF;
      dac_connect <= channel_select == CHS_DAC_OUT;
      fixed_ref_connect <= channel_select == CHS_FIXED_REF;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nref_external <= 1'b0;
      pref_supply <= 1'b1;
      pref_external <= 1'b0;
      pref_fixed <= 1'b0;
    end else begin
      nref_external <= conversion_config[CFG_NREF_BIT];
      pref_supply <= conversion_config[CFG_PREF_LSB +: PREF_W] == PREF_SUPPLY;
      pref_external <= conversion_config[CFG_PREF_LSB +: PREF_W] == PREF_EXTERNAL;
      pref_fixed <= conversion_config[CFG_PREF_LSB +: PREF_W] == PREF_FIXED;
    end
  end

  // ****************************************
  // Trigger timer and interrupt outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_timer_reset <= 1'b0;
    end else begin
      trigger_timer_reset <= compare_trigger;
    end
  end

  // Flag-level interrupt; stays up until software clears the flag or the IRQ enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_irq <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      conversion_irq <= conversion_done_flag & conversion_irq_enable;
      wake_request <= conversion_done_flag & conversion_irq_enable & sleep_active;
    end
  end

endmodule

// ---- testbench/sas_adc_seq_sva.sv ----
`timescale 1ns/1ps
module sas_adc_seq_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sas_pkg::APB_AW-1:0] paddr,
  input wire logic [sas_pkg::APB_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_active,
  input wire logic compare_trigger,
  input wire logic converter_powered,
  input wire logic sample_hold,
  input wire logic [3:0] ain_index,
  input wire logic ain_connect,
  input wire logic temp_ref_connect,
  input wire logic dac_connect,
  input wire logic fixed_ref_connect,
  input wire logic pref_supply,
  input wire logic pref_external,
  input wire logic pref_fixed,
  input wire logic trigger_timer_reset,
  input wire logic conversion_irq,
  input wire logic wake_request
);
  import sas_pkg::*;
  // ****
  // Checks
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait;
    $rose(penable) && psel |-> !pready ##1 pready;
  endproperty
  a_wait: assert property (p_wait) else $error("no single wait state");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_ctl_zero;
    pready && !pwrite && paddr == ADDR_CONTROL |-> prdata[31:7] == 0;
  endproperty
  a_ctl_zero: assert property (p_ctl_zero) else $error("control bit 7 set");
  property p_cfg_zero;
    pready && !pwrite && paddr == ADDR_CONFIG |-> !prdata[3];
  endproperty
  a_cfg_zero: assert property (p_cfg_zero) else $error("config bit 3 set");
  property p_wake;
    wake_request |-> conversion_irq && $past(sleep_active);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without cause");
  property p_trig;
    compare_trigger |=> trigger_timer_reset;
  endproperty
  a_trig: assert property (p_trig) else $error("timer not reset");
  property p_trig_src;
    trigger_timer_reset |-> $past(compare_trigger);
  endproperty
  a_trig_src: assert property (p_trig_src) else $error("stray timer reset");
  property p_power;
    sample_hold |-> converter_powered;
  endproperty
  a_power: assert property (p_power) else $error("sampling while off");
  property p_route;
    $onehot0({ain_connect, temp_ref_connect, dac_connect, fixed_ref_connect})
      && (!ain_connect || ain_index <= CHS_LAST_ANALOG[3:0]);
  endproperty
  a_route: assert property (p_route) else $error("bad routing");
  property p_pref;
    $onehot0({pref_supply, pref_external, pref_fixed});
  endproperty
  a_pref: assert property (p_pref) else $error("two references");
endmodule
bind sas_adc_seq sas_adc_seq_sva chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .sleep_active, .compare_trigger, .converter_powered, .sample_hold, .ain_index, .ain_connect,
  .temp_ref_connect, .dac_connect, .fixed_ref_connect, .pref_supply, .pref_external, .pref_fixed,
  .trigger_timer_reset, .conversion_irq, .wake_request);

// ---- testbench/sas_analog_model.sv ----
`timescale 1ns/1ps
module sas_analog_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_hold,
  input wire logic [sas_pkg::RES_W-1:0] sar_code,
  input wire logic [sas_pkg::RES_W-1:0] level,
  input wire logic rc_run,
  output logic cmp_high,
  output logic rc_tick
);
  // ****
  // Oscillator and comparator
  // ****
  logic [2:0] div;
  logic idle_bit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 3'h0;
      idle_bit <= 1'b0;
    end else begin
      div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
      idle_bit <= ~idle_bit;
    end
  end
  // Oscillator free-runs; only the tick is gated
  assign rc_tick = rc_run && div == 3'h4;
  // Outside hold the answer is junk, so it toggles
  assign cmp_high = sample_hold ? (sar_code <= level) : idle_bit;
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import sas_pkg::*;
  // ****
  // Signals
  // ****
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, sleep_active = 0, compare_trigger = 0, cmp_high, rc_tick, rc_run = 0;
  logic converter_powered, sample_hold, ain_connect, temp_ref_connect, dac_connect, fixed_ref_connect;
  logic nref_external, pref_supply, pref_external, pref_fixed, trigger_timer_reset, conversion_irq;
  logic wake_request;
  logic [9:0] sar_code, level = 0;
  logic [3:0] ain_index;
  logic [2:0] cs_tab[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  int hp[6] = '{1, 2, 4, 8, 16, 32};
  int err_total = 0, cmp_count = 0, t0, cyc = 0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  sas_adc_seq dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sleep_active, .rc_tick, .compare_trigger, .cmp_high, .converter_powered, .sample_hold, .sar_code,
    .ain_index, .ain_connect, .temp_ref_connect, .dac_connect, .fixed_ref_connect, .nref_external,
    .pref_supply, .pref_external, .pref_fixed, .trigger_timer_reset, .conversion_irq, .wake_request);
  sas_analog_model model (.pclk, .presetn, .sample_hold, .sar_code, .level, .rc_run, .cmp_high, .rc_tick);
  // ****
  // Tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    q = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(0, a, 8'h00);
    check(q, {24'h0, e});
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(0, ADDR_CONTROL, 8'h00);
      n++;
    end while (q[1] !== 1'b0 && n < 2000);
    if (n >= 2000) err_total++;
  endtask
  task automatic convert(input logic [7:0] cfg, input logic [9:0] lvl);
    level <= lvl;
    apb(1, ADDR_CONFIG, cfg);
    apb(1, ADDR_CONTROL, 8'h03);
    t0 = cyc;
    wait_done();
  endtask
  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rdc(ADDR_CONTROL, 8'h00);
    rdc(ADDR_CONFIG, 8'h00);
    check(pref_supply, 1);
    apb(0, 8'h18, 8'h00);
    check({slv, q[7:0]}, 9'h100);
    apb(1, ADDR_CONFIG, 8'hff);
    rdc(ADDR_CONFIG, 8'hf7);
    for (int i = 0; i < 8; i++) begin
      apb(1, ADDR_CONFIG, i[7:0]);
      repeat (2) @(negedge pclk);
      check({nref_external, pref_supply, pref_external, pref_fixed}, {i[2], i[1:0] == 0, i[1:0] == 2, i[1:0] == 3});
    end
    for (int c = 0; c < 32; c++) begin
      apb(1, ADDR_CONTROL, {1'b0, c[4:0], 2'b00});
      repeat (2) @(negedge pclk);
      check({ain_connect, temp_ref_connect, dac_connect, fixed_ref_connect}, {c < 14, c == 29, c == 30, c == 31});
      if (c < 14) check(ain_index, c[3:0]);
    end
    apb(1, ADDR_CONTROL, 8'h02);
    rdc(ADDR_CONTROL, 8'h00);
    apb(1, ADDR_CONTROL, 8'h03);
    rdc(ADDR_CONTROL, 8'h01);
    apb(1, ADDR_IRQ_ENABLE, 8'h01);
    for (int k = 0; k < 6; k++) begin
      convert({1'b1, cs_tab[k], 4'h0}, 10'h2c5 + k);
      check(cyc - t0 >= 23 * hp[k] && cyc - t0 <= 24 * hp[k] + 8, 1);
      rdc(ADDR_RESULT_HIGH, 8'h02);
      rdc(ADDR_RESULT_LOW, 8'hc5 + k);
      rdc(ADDR_DONE_FLAG, 8'h01);
      check(conversion_irq, 1);
      apb(1, ADDR_DONE_FLAG, 8'h01);
    end
    rdc(ADDR_DONE_FLAG, 8'h00);
    apb(1, ADDR_IRQ_ENABLE, 8'h00);
    convert(8'h00, 10'h2c5);
    rdc(ADDR_RESULT_HIGH, 8'hb1);
    rdc(ADDR_RESULT_LOW, 8'h40);
    rdc(ADDR_DONE_FLAG, 8'h01);
    check(conversion_irq, 0);
    apb(1, ADDR_RESULT_LOW, 8'hff);
    rdc(ADDR_RESULT_LOW, 8'h40);
    apb(1, ADDR_DONE_FLAG, 8'h01);
    level <= 10'h3ff;
    apb(1, ADDR_CONFIG, 8'h60);
    apb(1, ADDR_CONTROL, 8'h03);
    repeat (300) @(posedge pclk);
    apb(1, ADDR_CONTROL, 8'h01);
    rdc(ADDR_CONTROL, 8'h01);
    rdc(ADDR_RESULT_HIGH, 8'hff);
    rdc(ADDR_RESULT_LOW, 8'hc0);
    rdc(ADDR_DONE_FLAG, 8'h00);
    level <= 10'h155;
    apb(1, ADDR_CONFIG, 8'h80);
    compare_trigger <= 1;
    @(posedge pclk);
    compare_trigger <= 0;
    rdc(ADDR_CONTROL, 8'h03);
    wait_done();
    rdc(ADDR_RESULT_LOW, 8'h55);
    apb(1, ADDR_DONE_FLAG, 8'h01);
    apb(1, ADDR_CONFIG, 8'h60);
    apb(1, ADDR_CONTROL, 8'h03);
    repeat (50) @(posedge pclk);
    sleep_active <= 1;
    repeat (4) @(negedge pclk);
    check(converter_powered, 0);
    rdc(ADDR_CONTROL, 8'h01);
    rdc(ADDR_DONE_FLAG, 8'h00);
    sleep_active <= 0;
    rc_run <= 1;
    apb(1, ADDR_IRQ_ENABLE, 8'h01);
    apb(1, ADDR_CONFIG, 8'h30);
    apb(1, ADDR_CONTROL, 8'h03);
    repeat (2) @(negedge pclk);
    check(sample_hold, 0);
    @(posedge pclk);
    sleep_active <= 1;
    wait_done();
    check(wake_request, 1);
    apb(1, ADDR_DONE_FLAG, 8'h01);
    apb(1, ADDR_IRQ_ENABLE, 8'h00);
    apb(1, ADDR_CONTROL, 8'h03);
    wait_done();
    repeat (2) @(negedge pclk);
    check(converter_powered, 0);
    rdc(ADDR_CONTROL, 8'h01);
    sleep_active <= 0;
    repeat (3) @(negedge pclk);
    check(converter_powered, 1);
    apb(1, ADDR_CONTROL, 8'h03);
    repeat (20) @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rdc(ADDR_CONTROL, 8'h00);
    rdc(ADDR_CONFIG, 8'h00);
    check(converter_powered, 0);
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    print_verdict();
  end
endmodule
